/* File: common/cell_pkg.sv */
// Constants and types shared by the logic cell register design
package cell_pkg;
    // ---------------------------------------------
    // Register byte offsets
    // ---------------------------------------------
    localparam logic [7:0] OFF_CTRL    = 8'h00;
    localparam logic [7:0] OFF_CMD     = 8'h04;
    localparam logic [7:0] OFF_LOAD    = 8'h08;
    localparam logic [7:0] OFF_CASC    = 8'h0C;
    localparam logic [7:0] OFF_PRESET  = 8'h10;
    localparam logic [7:0] OFF_PLOAD   = 8'h14;
    localparam logic [7:0] OFF_COUNT   = 8'h18;
    localparam logic [7:0] OFF_UNKNOWN = 8'h1C;
    localparam logic [7:0] OFF_MC_CFG  = 8'h20;
    localparam logic [7:0] OFF_MC_DATA = 8'h24;
    localparam logic [7:0] OFF_CLK_CFG = 8'h28;
    localparam logic [7:0] OFF_MC_STAT = 8'h2C;
    localparam logic [7:0] OFF_PIN_CFG = 8'h30;
    localparam logic [7:0] OFF_PIN_OUT = 8'h34;
    localparam logic [7:0] OFF_PIN_IN  = 8'h38;
    // ---------------------------------------------
    // Field positions
    // ---------------------------------------------
    localparam int CTRL_CE      = 0;
    localparam int CTRL_CNT_EN  = 1;
    localparam int CTRL_UP      = 2;
    localparam int CTRL_CASC_EN = 3;
    localparam int CTRL_DEVRST  = 4;
    localparam int CMD_SCLR     = 0;
    localparam int CMD_SLOAD    = 1;
    localparam int CMD_ACLR     = 2;
    localparam int CLK_EDGE0    = 0;
    localparam int CLK_EDGE1    = 1;
    localparam int CLK_EN0      = 2;
    localparam int CLK_EN1      = 3;
    localparam int MC_CFG_W     = 4;
    localparam int PIN_FIELD_W  = 4;
    // ---------------------------------------------
    // Sizes and timing
    // ---------------------------------------------
    localparam int CLUSTER_SIZE = 10;
    localparam int NUM_MC       = 4;
    localparam int NUM_PINS     = 4;
    localparam int BLK_DIV      = 4;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ---------------------------------------------
    // Macrocell register types
    // ---------------------------------------------
    typedef enum logic [2:0] {
        MC_D, MC_T, MC_JK, MC_SR, MC_BYPASS
    } mc_mode_e;
endpackage

/* File: hdl/counter_element.sv */
// One logic element of the cluster in counter mode
`timescale 1ns/1ps
module counter_element (
    // Clock and clears
    input  wire logic clk,
    input  wire logic aclr,
    // Mode controls
    input  wire logic preset_emul,
    input  wire logic ce,
    input  wire logic cnt_en,
    input  wire logic up,
    input  wire logic sclr,
    input  wire logic sload,
    input  wire logic casc_en,
    // Data
    input  wire logic load_d,
    input  wire logic carry_in,
    input  wire logic casc_in,
    output logic      q,
    output logic      comb,
    output logic      carry_out
);
    logic stored_reg;
    logic sum;
    logic casc_val;
    logic next_val;

    // Count value table over data1, data2 and carry-in
    assign sum       = q ^ (cnt_en & carry_in);
    // Fast carry table over the same inputs plus the up direction
    assign carry_out = cnt_en & carry_in & (up ? q : ~q);
    assign casc_val  = casc_en ? (sum & casc_in) : sum;
    assign comb      = casc_val;
    // Load selects over count, clear gates to zero, both beat cascade
    assign next_val  = ~sclr & (sload ? load_d : casc_val);

    // Inverted storage turns the native clear into a preset
    always_ff @(posedge clk or posedge aclr) begin
        if (aclr) begin
            stored_reg <= 1'b0;
        end else if (ce) begin
            stored_reg <= preset_emul ? ~next_val : next_val;
        end
    end

    assign q = preset_emul ? ~stored_reg : stored_reg;
endmodule

/* File: hdl/macrocell_reg.sv */
// Product-term macrocell register of the embedded block
`timescale 1ns/1ps
module macrocell_reg (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         aclr,
    // Configuration
    input  wire logic [2:0]   mode,
    input  wire logic         clk_sel,
    input  wire logic [1:0]   blk_tick,
    // Data
    input  wire logic         a,
    input  wire logic         b,
    output logic              q,
    output logic              comb
);
    logic q_reg;
    logic q_next;

    always_comb begin
        case (cell_pkg::mc_mode_e'(mode))
            cell_pkg::MC_D:  q_next = a;
            cell_pkg::MC_T:  q_next = q_reg ^ a;
            cell_pkg::MC_JK: q_next = (a & ~q_reg) | (~b & q_reg);
            cell_pkg::MC_SR: q_next = a | (~b & q_reg);
            default:         q_next = q_reg;
        endcase
    end

    // Selected block clock brings its paired enable along
    always_ff @(posedge clk or posedge aclr) begin
        if (aclr) begin
            q_reg <= 1'b0;
        end else if (blk_tick[clk_sel]) begin
            q_reg <= q_next;
        end
    end

    assign q    = q_reg;
    assign comb = (mode == 3'(cell_pkg::MC_BYPASS)) ? a : q_reg;
endmodule

/* File: hdl/logic_cell_counter_register.sv */
// Logic cluster counter, macrocell and pin registers behind an AXI4-Lite slave
//
// Behaviour
// - Counter offers ce, count, direction, clear, load
// - Count enable and direction from element inputs; here both are shared ctrl_reg bits
// - Clear and load shared across whole cluster
// - Two three-input tables: count and carry; the carry table here also takes up
// - Load by selector, clear by zero gating
// - Clear or load beat cascade chain
// - Clear wins over simultaneous load
// - Registered and unregistered results both available
// - Clear from cluster-wide controls; preset chosen per element
// - Native async clear; preset by inversion
// - Preset-with-load registers unknown after device-wide reset
// - Enabled device reset overrides all controls
// - Preset registers go preset under device reset
// - Macrocell type D, T, JK, SR or bypass
// - Macrocell uses chosen block clock and enable
// - Each block clock serves either edge
// - Pin register captures input or drives output
// - Per-pin output enable allows open drain
// - Cluster holds ten elements with chains
`timescale 1ns/1ps
module logic_cell_counter_register #(
    parameter int N_ELEM = cell_pkg::CLUSTER_SIZE,
    parameter int N_MC   = cell_pkg::NUM_MC,
    parameter int N_PIN  = cell_pkg::NUM_PINS,
    parameter int DIV    = cell_pkg::BLK_DIV
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              sys_rst,
    // Device pins
    input  wire logic              device_wide_reset_n,
    input  wire logic [N_PIN-1:0]  pin_i,
    output logic      [N_PIN-1:0]  pin_o,
    output logic      [N_PIN-1:0]  pin_oe,
    // Observed registers
    output logic      [N_ELEM-1:0] count_q,
    output logic      [N_MC-1:0]   macro_q,
    // AXI4-Lite write address
    input  wire logic [7:0]        s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    // AXI4-Lite write response
    output logic      [1:0]        s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [7:0]        s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    // AXI4-Lite read data
    output logic      [31:0]       s_axi_rdata,
    output logic      [1:0]        s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready
);
    // ---------------------------------------------
    // Software registers
    // ---------------------------------------------
    logic [4:0]          ctrl_reg;
    logic [2:0]          cmd_reg;
    logic [N_ELEM-1:0]   load_reg;
    logic [N_ELEM-1:0]   casc_reg;
    logic [N_ELEM-1:0]   preset_reg;
    logic [N_ELEM-1:0]   pload_reg;
    logic [N_ELEM-1:0]   unknown_reg;
    logic [N_MC*4-1:0]   mc_cfg_reg;
    logic [N_MC*2-1:0]   mc_data_reg;
    logic [3:0]          clk_cfg_reg;
    logic [N_PIN*3-1:0]  pin_cfg_reg;
    logic [N_PIN-1:0]    pin_out_reg;
    logic [N_PIN-1:0]    pin_in_reg;
    logic [N_PIN-1:0]    pin_s1_reg;
    logic [N_PIN-1:0]    pin_s2_reg;
    logic [1:0]          devrst_sync_reg;
    logic                dev_rst_reg;
    logic                aclr_reg;

    // ---------------------------------------------
    // AXI4-Lite write path
    // ---------------------------------------------
    logic [7:0]  aw_addr_reg;
    logic        aw_have_reg;
    logic [31:0] w_data_reg;
    logic [3:0]  w_strb_reg;
    logic        w_have_reg;
    logic        wr_go;
    logic        wr_hit;

    assign s_axi_awready = ~aw_have_reg & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_have_reg & ~s_axi_bvalid;
    assign wr_go         = aw_have_reg & w_have_reg & ~s_axi_bvalid;

    always_comb begin
        case (aw_addr_reg)
            cell_pkg::OFF_CTRL, cell_pkg::OFF_CMD, cell_pkg::OFF_LOAD,
            cell_pkg::OFF_CASC, cell_pkg::OFF_PRESET, cell_pkg::OFF_PLOAD,
            cell_pkg::OFF_MC_CFG, cell_pkg::OFF_MC_DATA, cell_pkg::OFF_CLK_CFG,
            cell_pkg::OFF_PIN_CFG, cell_pkg::OFF_PIN_OUT: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            aw_have_reg  <= 1'b0;
            aw_addr_reg  <= 8'h00;
            w_have_reg   <= 1'b0;
            w_data_reg   <= 32'h0000_0000;
            w_strb_reg   <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= cell_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_reg <= 1'b1;
                aw_addr_reg <= {s_axi_awaddr[7:2], 2'h0};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_have_reg  <= 1'b0;
                w_have_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? cell_pkg::RESP_OKAY : cell_pkg::RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Byte-lane merge of the held write data onto an old value
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (st[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic wr_at(input logic go, input logic [7:0] a, input logic [7:0] off);
        return go && (a == off);
    endfunction

    // ---------------------------------------------
    // Configuration registers
    // ---------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_reg    <= 5'h00;
            load_reg    <= '0;
            casc_reg    <= '0;
            preset_reg  <= '0;
            pload_reg   <= '0;
            mc_cfg_reg  <= '0;
            mc_data_reg <= '0;
            clk_cfg_reg <= 4'h0;
            pin_cfg_reg <= '0;
            pin_out_reg <= '0;
        end else begin
            if (wr_at(wr_go, aw_addr_reg, cell_pkg::OFF_CTRL))
                ctrl_reg <= 5'(merge(32'(ctrl_reg), w_data_reg, w_strb_reg));
            if (wr_at(wr_go, aw_addr_reg, cell_pkg::OFF_LOAD))
                load_reg <= N_ELEM'(merge(32'(load_reg), w_data_reg, w_strb_reg));
            if (wr_at(wr_go, aw_addr_reg, cell_pkg::OFF_CASC))
                casc_reg <= N_ELEM'(merge(32'(casc_reg), w_data_reg, w_strb_reg));
            if (wr_at(wr_go, aw_addr_reg, cell_pkg::OFF_PRESET))
                preset_reg <= N_ELEM'(merge(32'(preset_reg), w_data_reg, w_strb_reg));
            if (wr_at(wr_go, aw_addr_reg, cell_pkg::OFF_PLOAD))
                pload_reg <= N_ELEM'(merge(32'(pload_reg), w_data_reg, w_strb_reg));
            if (wr_at(wr_go, aw_addr_reg, cell_pkg::OFF_MC_CFG))
                mc_cfg_reg <= (N_MC*4)'(merge(32'(mc_cfg_reg), w_data_reg, w_strb_reg));
            if (wr_at(wr_go, aw_addr_reg, cell_pkg::OFF_MC_DATA))
                mc_data_reg <= (N_MC*2)'(merge(32'(mc_data_reg), w_data_reg, w_strb_reg));
            if (wr_at(wr_go, aw_addr_reg, cell_pkg::OFF_CLK_CFG))
                clk_cfg_reg <= 4'(merge(32'(clk_cfg_reg), w_data_reg, w_strb_reg));
            if (wr_at(wr_go, aw_addr_reg, cell_pkg::OFF_PIN_CFG))
                pin_cfg_reg <= (N_PIN*3)'(merge(32'(pin_cfg_reg), w_data_reg, w_strb_reg));
            if (wr_at(wr_go, aw_addr_reg, cell_pkg::OFF_PIN_OUT))
                pin_out_reg <= N_PIN'(merge(32'(pin_out_reg), w_data_reg, w_strb_reg));
        end
    end

    // Command strobes last one cycle and act on the whole cluster
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cmd_reg <= 3'h0;
        end else if (wr_at(wr_go, aw_addr_reg, cell_pkg::OFF_CMD) && w_strb_reg[0]) begin
            cmd_reg <= w_data_reg[2:0];
        end else begin
            cmd_reg <= 3'h0;
        end
    end

    // ---------------------------------------------
    // Device-wide reset and cluster clear
    // ---------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            devrst_sync_reg <= 2'h3;
            dev_rst_reg     <= 1'b0;
            aclr_reg        <= 1'b0;
        end else begin
            devrst_sync_reg <= {devrst_sync_reg[0], device_wide_reset_n};
            dev_rst_reg     <= ctrl_reg[cell_pkg::CTRL_DEVRST] & ~devrst_sync_reg[1];
            aclr_reg        <= cmd_reg[cell_pkg::CMD_ACLR];
        end
    end

    // Async clear path of every counter element, macrocell and pin register
    logic cell_clr;
    assign cell_clr = sys_rst | aclr_reg | dev_rst_reg;

    // ---------------------------------------------
    // Logic cluster counter
    // ---------------------------------------------
    logic [N_ELEM:0]   carry;
    logic [N_ELEM-1:0] elem_q;
    logic [N_ELEM-1:0] elem_comb;
    logic              sclr;
    logic              sload;

    assign sclr     = cmd_reg[cell_pkg::CMD_SCLR];
    assign sload    = cmd_reg[cell_pkg::CMD_SLOAD];
    assign carry[0] = 1'b1;

    generate
        for (genvar i = 0; i < N_ELEM; i++) begin : g_elem
            counter_element u_elem (
                .clk         (clk),
                .aclr        (cell_clr),
                .preset_emul (preset_reg[i]),
                .ce          (ctrl_reg[cell_pkg::CTRL_CE]),
                .cnt_en      (ctrl_reg[cell_pkg::CTRL_CNT_EN]),
                .up          (ctrl_reg[cell_pkg::CTRL_UP]),
                .sclr        (sclr),
                .sload       (sload),
                .casc_en     (ctrl_reg[cell_pkg::CTRL_CASC_EN]),
                .load_d      (load_reg[i]),
                .carry_in    (carry[i]),
                .casc_in     (casc_reg[i]),
                .q           (elem_q[i]),
                .comb        (elem_comb[i]),
                .carry_out   (carry[i+1])
            );
        end
    endgenerate

    // Preset-with-load registers have no known value after a device-wide reset
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            unknown_reg <= '0;
        end else if (dev_rst_reg) begin
            unknown_reg <= pload_reg & preset_reg;
        end else if (sload && ctrl_reg[cell_pkg::CTRL_CE]) begin
            unknown_reg <= '0;
        end
    end

    // ---------------------------------------------
    // Block clocks for the macrocells
    // ---------------------------------------------
    logic [$clog2(DIV)-1:0] div_reg;
    logic                   slow_reg;
    logic                   slow_rise;
    logic                   slow_fall;
    logic [1:0]             blk_tick;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            div_reg  <= '0;
            slow_reg <= 1'b0;
        end else if (div_reg == $clog2(DIV)'(DIV - 1)) begin
            div_reg  <= '0;
            slow_reg <= ~slow_reg;
        end else begin
            div_reg <= div_reg + 1'b1;
        end
    end

    assign slow_rise = (div_reg == $clog2(DIV)'(DIV - 1)) & ~slow_reg;
    assign slow_fall = (div_reg == $clog2(DIV)'(DIV - 1)) & slow_reg;
    // Each block clock picks an edge; mixed edges take both clocks
    assign blk_tick[0] = clk_cfg_reg[cell_pkg::CLK_EN0] &
                         (clk_cfg_reg[cell_pkg::CLK_EDGE0] ? slow_fall : slow_rise);
    assign blk_tick[1] = clk_cfg_reg[cell_pkg::CLK_EN1] &
                         (clk_cfg_reg[cell_pkg::CLK_EDGE1] ? slow_fall : slow_rise);

    logic [N_MC-1:0] mc_q;
    logic [N_MC-1:0] mc_comb;

    generate
        for (genvar m = 0; m < N_MC; m++) begin : g_mc
            macrocell_reg u_mc (
                .clk     (clk),
                .aclr    (cell_clr),
                .mode    (mc_cfg_reg[m*cell_pkg::MC_CFG_W +: 3]),
                .clk_sel (mc_cfg_reg[m*cell_pkg::MC_CFG_W + 3]),
                .blk_tick(blk_tick),
                .a       (mc_data_reg[m]),
                .b       (mc_data_reg[N_MC + m]),
                .q       (mc_q[m]),
                .comb    (mc_comb[m])
            );
        end
    endgenerate

    // ---------------------------------------------
    // Pin elements
    // ---------------------------------------------
    logic [N_PIN-1:0] pin_oe_cfg;
    logic [N_PIN-1:0] pin_outreg;
    logic [N_PIN-1:0] pin_od;

    assign pin_oe_cfg = pin_cfg_reg[0 +: N_PIN];
    assign pin_outreg = pin_cfg_reg[N_PIN +: N_PIN];
    assign pin_od     = pin_cfg_reg[2*N_PIN +: N_PIN];

    always_ff @(posedge clk or posedge cell_clr) begin
        if (cell_clr) begin
            pin_s1_reg <= '0;
            pin_s2_reg <= '0;
            pin_in_reg <= '0;
            pin_o      <= '0;
            pin_oe     <= '0;
        end else begin
            pin_s1_reg <= pin_i;
            pin_s2_reg <= pin_s1_reg;
            for (int p = 0; p < N_PIN; p++) begin
                // Input capture when not used as output register
                if (!pin_outreg[p])
                    pin_in_reg[p] <= pin_s2_reg[p];
                pin_o[p]  <= pin_od[p] ? 1'b0 : pin_out_reg[p];
                pin_oe[p] <= pin_od[p] ? ~pin_out_reg[p] & pin_oe_cfg[p]
                                       : pin_oe_cfg[p];
            end
        end
    end

    // ---------------------------------------------
    // Observed outputs and read path
    // ---------------------------------------------
    assign count_q = elem_q;
    assign macro_q = mc_q;

    logic [31:0] rd_val;
    logic        rd_hit;

    always_comb begin
        rd_val = 32'h0000_0000;
        rd_hit = 1'b1;
        case ({s_axi_araddr[7:2], 2'h0})
            cell_pkg::OFF_CTRL:    rd_val = 32'(ctrl_reg);
            cell_pkg::OFF_CMD:     rd_val = 32'h0000_0000;
            cell_pkg::OFF_LOAD:    rd_val = 32'(load_reg);
            cell_pkg::OFF_CASC:    rd_val = 32'(casc_reg);
            cell_pkg::OFF_PRESET:  rd_val = 32'(preset_reg);
            cell_pkg::OFF_PLOAD:   rd_val = 32'(pload_reg);
            cell_pkg::OFF_COUNT:   rd_val = 32'({carry[N_ELEM], elem_comb, elem_q});
            cell_pkg::OFF_UNKNOWN: rd_val = 32'(unknown_reg);
            cell_pkg::OFF_MC_CFG:  rd_val = 32'(mc_cfg_reg);
            cell_pkg::OFF_MC_DATA: rd_val = 32'(mc_data_reg);
            cell_pkg::OFF_CLK_CFG: rd_val = 32'(clk_cfg_reg);
            cell_pkg::OFF_MC_STAT: rd_val = 32'({mc_comb, mc_q});
            cell_pkg::OFF_PIN_CFG: rd_val = 32'(pin_cfg_reg);
            cell_pkg::OFF_PIN_OUT: rd_val = 32'(pin_out_reg);
            cell_pkg::OFF_PIN_IN:  rd_val = 32'(pin_in_reg);
            default:               rd_hit = 1'b0;
        endcase
    end

    assign s_axi_arready = ~s_axi_rvalid;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= cell_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_val;
            s_axi_rresp  <= rd_hit ? cell_pkg::RESP_OKAY : cell_pkg::RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule

/* File: verif/logic_cell_counter_register_monitor.sv */
// Handshake checker on the register bus of the logic cell block
`timescale 1ns/1ps
module logic_cell_counter_register_monitor (
    // Clock, reset and bus
    input wire logic        clk, sys_rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid,
    input wire logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid,
    input wire logic        s_axi_arready, s_axi_rvalid, s_axi_rready,
    input wire logic [1:0]  s_axi_bresp, s_axi_rresp,
    input wire logic [31:0] s_axi_rdata
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    a_write_answer:
        assert property (wr_taken |-> ##2 s_axi_bvalid) else $error("write not answered");
    a_bresp_stands:
        assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped");
    a_write_refused:
        assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("aw taken");
    a_bresp_code:
        assert property (s_axi_bvalid |-> s_axi_bresp inside {2'h0, 2'h2}) else $error("bresp");
    a_read_answer:
        assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no rvalid");
    a_rdata_stands:
        assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped");
    a_read_refused:
        assert property (s_axi_rvalid |-> !s_axi_arready) else $error("ar taken");
    a_rresp_code:
        assert property (s_axi_rvalid |-> s_axi_rresp inside {2'h0, 2'h2}) else $error("rresp");
endmodule

/* File: verif/pin_partner.sv */
// Far-side pad model: block driver, board driver, else pull-up level
`timescale 1ns/1ps
module pin_partner (
    // Pads
    input wire logic [3:0] pin_o, pin_oe, ext_d, ext_oe,
    output logic     [3:0] pin_i
);
    assign pin_i = (pin_oe & pin_o) | (~pin_oe & ext_oe & ext_d) | (~pin_oe & ~ext_oe);
endmodule

/* File: verif/logic_cell_counter_register_tb_top.sv */
// Self-checking bench for the logic cell counter register block
`timescale 1ns/1ps
module logic_cell_counter_register_tb_top;
    logic        clk = 0, sys_rst = 1, device_wide_reset_n = 1, s_axi_awvalid = 0;
    logic        s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, mq[$], m;
    logic [3:0]  s_axi_wstrb = 4'hF, ext_d = '0, ext_oe = '0, pin_i, pin_o, pin_oe, macro_q;
    logic [1:0]  s_axi_bresp, s_axi_rresp, bq[$];
    logic [9:0]  count_q, v, p;
    logic [33:0] rq[$], e;
    logic [15:0] seed = 16'hC12E;
    int          fail_count = 0, comparisons = 0, cyc = 0, n;
    logic_cell_counter_register #(.DIV(2)) u_logic_cell_counter_register (.*);
    pin_partner u_pin_partner (.*);
    initial begin
        forever #4 clk = ~clk;
    end
    function automatic logic [15:0] rnd();
        seed ^= seed << 7;
        seed ^= seed >> 9;
        seed ^= seed << 8;
        return seed;
    endfunction
    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        if (fail_count == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] dt, input logic [1:0] r = 2'h0);
        bq.push_back(r);
        s_axi_awaddr <= a;
        s_axi_wdata <= dt;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        // Each channel is released at the edge that takes it
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (s_axi_awvalid || s_axi_wvalid);
        do @(posedge clk); while (!s_axi_bvalid);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic [31:0] m = 32'h3FF, input logic [1:0] r = 2'h0);
        rq.push_back({r, e});
        mq.push_back(m);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do @(posedge clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'h0;
        do @(posedge clk); while (!s_axi_rvalid);
    endtask
    // Response watcher: oldest note against each answer
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (s_axi_bvalid && s_axi_bready) check(34'(s_axi_bresp), 34'(bq.pop_front()));
        if (s_axi_rvalid && s_axi_rready) begin
            m = mq.pop_front();
            e = rq.pop_front();
            check({s_axi_rresp, s_axi_rdata & m}, e);
            if (m == 32'h3FF) check(34'(count_q), 34'(e[9:0]));
            if (m == 32'hFF) check(34'(macro_q), 34'(e[3:0]));
        end
    end
    initial begin
        #200000;
        fail_count++;
        give_verdict();
    end
    initial begin
        repeat (3) @(posedge clk);
        sys_rst <= 1'h0;
        @(posedge clk);
        rd(cell_pkg::OFF_CTRL, 32'h0, 32'hFFFFFFFF);
        rd(8'h3C, 32'h0, 32'hFFFFFFFF, 2'h2);
        wr(cell_pkg::OFF_COUNT, 32'h1, 2'h2);
        v = 10'(rnd());
        wr(cell_pkg::OFF_LOAD, 32'(v));
        wr(cell_pkg::OFF_CTRL, 32'h1);
        wr(cell_pkg::OFF_CMD, 32'h2);
        rd(cell_pkg::OFF_COUNT, 32'(v));
        wr(cell_pkg::OFF_CTRL, 32'h0);
        wr(cell_pkg::OFF_CMD, 32'h1);
        rd(cell_pkg::OFF_COUNT, 32'(v));
        wr(cell_pkg::OFF_CTRL, 32'h1);
        wr(cell_pkg::OFF_CMD, 32'h3);
        rd(cell_pkg::OFF_COUNT, 32'h0);
        wr(cell_pkg::OFF_CMD, 32'h2);
        for (int k = 0; k < 2; k++) begin
            wr(cell_pkg::OFF_CTRL, k ? 32'h3 : 32'h7);
            n = cyc;
            wr(cell_pkg::OFF_CTRL, 32'h1);
            v = k ? v - 10'(cyc - n) : v + 10'(cyc - n);
            rd(cell_pkg::OFF_COUNT, 32'(v));
        end
        p = 10'(rnd());
        wr(cell_pkg::OFF_PRESET, 32'(p));
        wr(cell_pkg::OFF_PLOAD, 32'h3FF);
        wr(cell_pkg::OFF_CTRL, 32'h11);
        device_wide_reset_n <= 1'h0;
        repeat (6) @(posedge clk);
        rd(cell_pkg::OFF_COUNT, 32'(p));
        rd(cell_pkg::OFF_UNKNOWN, 32'(p));
        rd(cell_pkg::OFF_MC_STAT, 32'h0, 32'hFF);
        device_wide_reset_n <= 1'h1;
        repeat (4) @(posedge clk);
        ext_d <= 4'(rnd());
        wr(cell_pkg::OFF_CLK_CFG, 32'h4);
        wr(cell_pkg::OFF_MC_CFG, 32'h0);
        wr(cell_pkg::OFF_MC_DATA, 32'(ext_d));
        repeat (8) @(posedge clk);
        rd(cell_pkg::OFF_MC_STAT, 32'({ext_d, ext_d}), 32'hFF);
        wr(cell_pkg::OFF_MC_CFG, 32'h4444);
        wr(cell_pkg::OFF_MC_DATA, 32'({~ext_d}));
        rd(cell_pkg::OFF_MC_STAT, 32'({~ext_d, ext_d}), 32'hFF);
        for (int k = 0; k < 3; k++) begin
            ext_d <= 4'(rnd());
            ext_oe <= k == 2 ? 4'hF : 4'h0;
            @(posedge clk);
            wr(cell_pkg::OFF_PIN_OUT, 32'(ext_d));
            wr(cell_pkg::OFF_PIN_CFG, k == 0 ? 32'hF : (k == 1 ? 32'hF0F : 32'h0));
            repeat (6) @(posedge clk);
            rd(cell_pkg::OFF_PIN_IN, 32'(ext_d), 32'hF);
        end
        give_verdict();
    end
endmodule
bind logic_cell_counter_register logic_cell_counter_register_monitor u_mon (.*);
